/* hw/thpf_defines.vh */
// constants for the tile hardware prefetch unit
// included by the prefetch top and its table memory
`ifndef THPF_DEFINES_VH
`define THPF_DEFINES_VH
`define THPF_LINE_BITS     6
`define THPF_PAGE_BITS     12
`define THPF_ADDR_W        40
`define THPF_LINE_ADDR_W   34
`define THPF_LIP_IN_PAGE   6
`define THPF_N_DETECT      48
`define THPF_IPT_DEPTH     64
`define THPF_IPT_IDX_W     6
`define THPF_FB_DEPTH      8
`define THPF_DIR_UP        1'b0
`define THPF_DIR_DOWN      1'b1
`define THPF_CONF_MAX      2'h3
`define THPF_CONF_ISSUE    2'h2
`define THPF_LINE_LAST     6'h3f
`define THPF_LINE_FIRST    6'h00
`endif

/* hw/thpf_ipt_mem.v */
// tracking table of the instruction-indexed stride prefetcher
// one write port, one read port, registered read data, no reset of contents
`timescale 1ns/1ps
`include "thpf_defines.vh"

module thpf_ipt_mem #(
	parameter WIDTH = 48,
	parameter DEPTH = `THPF_IPT_DEPTH,
	parameter AW    = `THPF_IPT_IDX_W
) (
	// clock
	input  wire             mclk,
	// read port
	input  wire [AW-1:0]    rd_idx,
	output reg  [WIDTH-1:0] rd_data,
	// write port
	input  wire             wr_en,
	input  wire [AW-1:0]    wr_idx,
	input  wire [WIDTH-1:0] wr_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];

	// registered read keeps the table timing-clean
	always @(posedge mclk) begin
		// forward a write to the entry being read, so back to back
		// accesses from one pc see each other
		if (wr_en && wr_idx == rd_idx) begin
			rd_data <= wr_data;
		end else begin
			rd_data <= mem[rd_idx];
		end
		if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
	end
endmodule

/* hw/thpf_top.v */
// tile hardware prefetch unit: l1 stride prefetcher, l2 stream prefetcher
// and software prefetch handling; one clock, addresses are byte addresses
// assumes the caches answer presence lookups combinationally
`timescale 1ns/1ps
`include "thpf_defines.vh"

module thpf_top #(
	parameter AW       = `THPF_ADDR_W,
	parameter NDET     = `THPF_N_DETECT,
	parameter FBN      = `THPF_FB_DEPTH
) (
	// clock and reset
	input  wire          mclk,
	input  wire          sys_rst,
	// core data access stream
	input  wire          acc_valid,
	input  wire [AW-1:0] acc_addr,
	input  wire [AW-1:0] acc_pc,
	input  wire          acc_lp,
	input  wire          acc_cacheable,
	// software prefetch hints
	input  wire          swp_valid,
	output wire          swp_ready,
	input  wire [AW-1:0] swp_addr,
	input  wire          prefetch_to_l2_hint,
	input  wire          swp_tlb_hit,
	// page walk unit
	output reg           pwu_req_q,
	output reg  [AW-1:0] pwu_addr_q,
	input  wire          pwu_done,
	// l1 side
	output reg           l1_pf_valid_q,
	output reg  [AW-1:0] l1_pf_addr_q,
	input  wire          l1_pf_ready,
	input  wire          l1_present,
	input  wire          l1_fill_done,
	input  wire [AW-1:0] l1_fill_addr,
	output wire [FBN-1:0] fb_busy,
	// l2 side
	output reg           l2_pf_valid_q,
	output reg  [AW-1:0] l2_pf_addr_q,
	input  wire          l2_pf_ready,
	input  wire          l2_present,
	output reg           mem_req_q,
	output reg  [AW-1:0] mem_addr_q
);
	localparam LAW = AW - `THPF_LINE_BITS;
	localparam PGW = AW - `THPF_PAGE_BITS;
	localparam TW  = 1 + LAW + 2 + 16 + LAW;

	// software prefetch sequencer states
	localparam S_IDLE = 3'b001;
	localparam S_WALK = 3'b010;
	localparam S_ISS  = 3'b100;

	wire [LAW-1:0] acc_line = acc_addr[AW-1:`THPF_LINE_BITS];
	wire [PGW-1:0] acc_page = acc_addr[AW-1:`THPF_PAGE_BITS];

	// ---------------- stride prefetcher ----------------
	// pc xor lp index
	wire [`THPF_IPT_IDX_W-1:0] ipt_idx =
		acc_pc[`THPF_IPT_IDX_W-1:0] ^ {{(`THPF_IPT_IDX_W-1){1'b0}}, acc_lp};
	wire [TW-1:0] ipt_rd;
	reg           s1_v_q;
	reg  [LAW-1:0] s1_line_q;
	reg  [`THPF_IPT_IDX_W-1:0] s1_idx_q;
	reg            s1_cach_q;
	reg  [15:0]    s1_tag_q;
	// table contents are never reset, so validity lives in flops
	reg  [`THPF_IPT_DEPTH-1:0] ipt_vld_q;
	reg            e_v_q;
	// entry: valid, stride, confidence, pc tag, last line
	wire           e_v    = e_v_q;
	wire [LAW-1:0] e_strd = ipt_rd[2*LAW+17:LAW+18];
	wire [1:0]     e_conf = ipt_rd[LAW+17:LAW+16];
	wire [15:0]    e_tag  = ipt_rd[15+LAW:LAW];
	wire [LAW-1:0] e_line = ipt_rd[LAW-1:0];
	wire [LAW-1:0] stride = s1_line_q - e_line;
	wire           e_hit  = e_v && (e_tag == s1_tag_q);
	// a changed stride restarts the count at one sighting
	wire [1:0]     n_conf = !e_hit ? 2'h0 : (stride != e_strd) ? 2'h1 :
		(e_conf == `THPF_CONF_MAX) ? e_conf : e_conf + 2'h1;
	wire [LAW-1:0] pf_line = s1_line_q + stride;
	wire [TW-1:0]  ipt_wr = {1'b1, e_hit ? stride : {LAW{1'b0}}, n_conf,
		s1_tag_q, s1_line_q};

	thpf_ipt_mem #(.WIDTH(TW)) u_ipt (
		.mclk    (mclk),
		.rd_idx  (ipt_idx),
		.rd_data (ipt_rd),
		.wr_en   (s1_v_q),
		.wr_idx  (s1_idx_q),
		.wr_data (ipt_wr)
	);

	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_v_q    <= 1'b0;
			ipt_vld_q <= {`THPF_IPT_DEPTH{1'b0}};
			e_v_q     <= 1'b0;
			s1_line_q <= {LAW{1'b0}};
			s1_idx_q  <= {`THPF_IPT_IDX_W{1'b0}};
			s1_cach_q <= 1'b0;
			s1_tag_q  <= 16'h0000;
		end else begin
			s1_v_q    <= acc_valid;
			s1_line_q <= acc_line;
			s1_idx_q  <= ipt_idx;
			s1_cach_q <= acc_cacheable;
			s1_tag_q  <= acc_pc[15:0];
			// forward a same-cycle write, as the table itself does
			e_v_q     <= ipt_vld_q[ipt_idx] ||
				(s1_v_q && s1_idx_q == ipt_idx);
			if (s1_v_q) begin
				ipt_vld_q[s1_idx_q] <= 1'b1;
			end
		end
	end

	wire same_pg = pf_line[LAW-1:`THPF_LIP_IN_PAGE] ==
		s1_line_q[LAW-1:`THPF_LIP_IN_PAGE];
	wire l1_cand = s1_v_q && s1_cach_q && e_hit && (stride != {LAW{1'b0}})
		&& (n_conf >= `THPF_CONF_ISSUE) && same_pg;

	// ---------------- fill buffers ----------------
	reg [FBN-1:0]  fb_v_q;
	reg [LAW-1:0]  fb_line_q [0:FBN-1];
	wire [FBN-1:0] fb_match_pf;
	wire [FBN-1:0] fb_match_sw;
	wire [FBN-1:0] fb_done;
	wire [LAW-1:0] fill_line = l1_fill_addr[AW-1:`THPF_LINE_BITS];
	reg  [AW-1:0]  sw_addr_q;
	wire [LAW-1:0] swq_line  = sw_addr_q[AW-1:`THPF_LINE_BITS];
	assign fb_busy = fb_v_q;

	genvar g;
	generate
		for (g = 0; g < FBN; g = g + 1) begin : g_fb
			assign fb_match_pf[g] = fb_v_q[g] && fb_line_q[g] == pf_line;
			assign fb_match_sw[g] = fb_v_q[g] && fb_line_q[g] == swq_line;
			assign fb_done[g] = fb_v_q[g] && l1_fill_done &&
				fb_line_q[g] == fill_line;
		end
	endgenerate

	// lowest free fill buffer
	reg [FBN-1:0] fb_free;
	integer i;
	always @* begin
		fb_free = {FBN{1'b0}};
		for (i = FBN - 1; i >= 0; i = i - 1) begin
			if (!fb_v_q[i]) begin
				fb_free = {FBN{1'b0}};
				fb_free[i] = 1'b1;
			end
		end
	end

	// ---------------- software prefetch sequencer ----------------
	reg [2:0]    sw_st_q;
	reg          sw_l2_q;
	wire sw_l1_go = (sw_st_q == S_ISS) && !sw_l2_q;
	wire sw_l2_go = (sw_st_q == S_ISS) && sw_l2_q;
	wire sw_l1_dup = l1_present || (|fb_match_sw);
	// l1 sw issue needs a free fill buffer unless dropped as duplicate
	wire sw_l1_ok = sw_l1_go && (sw_l1_dup || (l1_pf_ready && |fb_free));
	wire sw_l2_ok = sw_l2_go && (l2_present || l2_pf_ready);
	assign swp_ready = (sw_st_q == S_IDLE);

	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			sw_st_q   <= S_IDLE;
			sw_addr_q <= {AW{1'b0}};
			sw_l2_q   <= 1'b0;
			pwu_req_q <= 1'b0;
			pwu_addr_q <= {AW{1'b0}};
		end else begin
			pwu_req_q <= 1'b0;
			case (sw_st_q)
				S_IDLE: begin
					if (swp_valid) begin
						sw_addr_q <= swp_addr;
						sw_l2_q   <= prefetch_to_l2_hint;
						if (!swp_tlb_hit) begin
							pwu_req_q  <= 1'b1;
							pwu_addr_q <= swp_addr;
							sw_st_q    <= S_WALK;
						end else begin
							sw_st_q <= S_ISS;
						end
					end
				end
				S_WALK: begin
					if (pwu_done) begin
						sw_st_q <= S_ISS;
					end
				end
				S_ISS: begin
					if (sw_l1_ok || sw_l2_ok) begin
						sw_st_q <= S_IDLE;
					end
				end
				default: sw_st_q <= S_IDLE;
			endcase
		end
	end

	// ---------------- l1 request mux and fill buffer bookkeeping -----
	// drop present or outstanding lines
	wire hw_l1_ok = l1_cand && !l1_present && !(|fb_match_pf) && (|fb_free)
		&& !sw_l1_go;
	wire sw_l1_alloc = sw_l1_ok && !sw_l1_dup;
	wire l1_issue = (sw_l1_alloc || hw_l1_ok) && l1_pf_ready;

	integer k;
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			fb_v_q        <= {FBN{1'b0}};
			l1_pf_valid_q <= 1'b0;
			l1_pf_addr_q  <= {AW{1'b0}};
			for (k = 0; k < FBN; k = k + 1) begin
				fb_line_q[k] <= {LAW{1'b0}};
			end
		end else begin
			l1_pf_valid_q <= l1_issue;
			fb_v_q <= fb_v_q & ~fb_done;
			if (l1_issue) begin
				l1_pf_addr_q <= {sw_l1_alloc ? swq_line : pf_line,
					{`THPF_LINE_BITS{1'b0}}};
				fb_v_q <= (fb_v_q & ~fb_done) | fb_free;
				for (k = 0; k < FBN; k = k + 1) begin
					if (fb_free[k]) begin
						fb_line_q[k] <= sw_l1_alloc ? swq_line : pf_line;
					end
				end
			end
		end
	end

	// ---------------- l2 stream detectors ----------------
	reg [NDET-1:0] d_v_q;
	reg [NDET-1:0] d_dir_q;
	reg [NDET-1:0] d_live_q;
	reg [PGW-1:0]  d_pg_q  [0:NDET-1];
	reg [5:0]      d_last_q [0:NDET-1];
	reg [5:0]      d_next_q [0:NDET-1];
	reg [5:0]      alloc_ptr_q;
	wire [NDET-1:0] d_hit;
	wire [NDET-1:0] d_want;
	wire [5:0]     acc_lip = acc_line[5:0];

	generate
		for (g = 0; g < NDET; g = g + 1) begin : g_det
			assign d_hit[g]  = d_v_q[g] && d_pg_q[g] == acc_page;
			assign d_want[g] = d_live_q[g];
		end
	endgenerate

	// pick lowest detector with a pending prefetch
	reg [5:0] pick;
	reg       pick_v;
	integer j;
	always @* begin
		pick   = 6'h00;
		pick_v = 1'b0;
		for (j = NDET - 1; j >= 0; j = j - 1) begin
			if (d_want[j]) begin
				pick   = j[5:0];
				pick_v = 1'b1;
			end
		end
	end
	wire [LAW-1:0] st_line = {d_pg_q[pick], d_next_q[pick]};
	wire l2_hw_go = pick_v && !sw_l2_go;
	wire l2_hw_ok = l2_hw_go && (l2_present || l2_pf_ready);

	integer m;
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			d_v_q       <= {NDET{1'b0}};
			d_dir_q     <= {NDET{1'b0}};
			d_live_q    <= {NDET{1'b0}};
			alloc_ptr_q <= 6'h00;
			for (m = 0; m < NDET; m = m + 1) begin
				d_pg_q[m]   <= {PGW{1'b0}};
				d_last_q[m] <= `THPF_LINE_FIRST;
				d_next_q[m] <= `THPF_LINE_FIRST;
			end
		end else begin
			// advance stream; stop at region edge
			if (l2_hw_ok) begin
				if (d_dir_q[pick] == `THPF_DIR_UP) begin
					if (d_next_q[pick] == `THPF_LINE_LAST)
						d_live_q[pick] <= 1'b0;
					else
						d_next_q[pick] <= d_next_q[pick] + 6'h01;
				end else begin
					if (d_next_q[pick] == `THPF_LINE_FIRST)
						d_live_q[pick] <= 1'b0;
					else
						d_next_q[pick] <= d_next_q[pick] - 6'h01;
				end
			end
			if (acc_valid) begin
				if (|d_hit) begin
					for (m = 0; m < NDET; m = m + 1) begin
						if (d_hit[m]) begin
							d_last_q[m] <= acc_lip;
							if (acc_lip == d_last_q[m] + 6'h01 &&
								d_last_q[m] != `THPF_LINE_LAST) begin
								d_dir_q[m]  <= `THPF_DIR_UP;
								d_live_q[m] <= 1'b1;
								d_next_q[m] <= acc_lip + 6'h01;
								if (acc_lip == `THPF_LINE_LAST)
									d_live_q[m] <= 1'b0;
							end else if (acc_lip + 6'h01 == d_last_q[m] &&
								d_last_q[m] != `THPF_LINE_FIRST) begin
								d_dir_q[m]  <= `THPF_DIR_DOWN;
								d_live_q[m] <= 1'b1;
								d_next_q[m] <= acc_lip - 6'h01;
								if (acc_lip == `THPF_LINE_FIRST)
									d_live_q[m] <= 1'b0;
							end
						end
					end
				end else begin
					d_v_q[alloc_ptr_q]    <= 1'b1;
					d_live_q[alloc_ptr_q] <= 1'b0;
					d_pg_q[alloc_ptr_q]   <= acc_page;
					d_last_q[alloc_ptr_q] <= acc_lip;
					alloc_ptr_q <= (alloc_ptr_q == NDET - 1) ? 6'h00 :
						alloc_ptr_q + 6'h01;
				end
			end
		end
	end

	// ---------------- l2 requests and memory forwarding ----------
	wire l2_issue = (sw_l2_ok || l2_hw_ok) && !l2_present;
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			l2_pf_valid_q <= 1'b0;
			l2_pf_addr_q  <= {AW{1'b0}};
			mem_req_q     <= 1'b0;
			mem_addr_q    <= {AW{1'b0}};
		end else begin
			// issue to l2, forward miss to memory
			l2_pf_valid_q <= l2_issue;
			mem_req_q     <= l2_issue;
			if (l2_issue) begin
				l2_pf_addr_q <= {sw_l2_go ? swq_line : st_line,
					{`THPF_LINE_BITS{1'b0}}};
				mem_addr_q   <= {sw_l2_go ? swq_line : st_line,
					{`THPF_LINE_BITS{1'b0}}};
			end
		end
	end
endmodule

/* verification/thpf_assertions.sv */
// checker for the tile prefetch top, bound to its ports
// assumes one clock domain with an active-high async reset
`timescale 1ns/1ps
module thpf_assertions #(
	parameter AW  = 40,
	parameter FBN = 8
) (
	// clock and reset
	input wire           mclk,
	input wire           sys_rst,
	// software prefetch
	input wire           swp_valid,
	input wire           swp_ready,
	input wire [AW-1:0]  swp_addr,
	input wire           prefetch_to_l2_hint,
	input wire           swp_tlb_hit,
	// requests out
	input wire           pwu_req_q,
	input wire [AW-1:0]  pwu_addr_q,
	input wire           l1_pf_valid_q,
	input wire [AW-1:0]  l1_pf_addr_q,
	input wire [FBN-1:0] fb_busy,
	input wire           l2_pf_valid_q,
	input wire [AW-1:0]  l2_pf_addr_q,
	input wire           mem_req_q,
	input wire [AW-1:0]  mem_addr_q
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	// accepted hint and its line address
	wire          sw_take = swp_valid && swp_ready;
	wire [AW-1:0] sw_line = {swp_addr[AW-1:6], 6'h00};

	a_quiet_reset:
	assert property ($fell(sys_rst) |-> !l1_pf_valid_q && !l2_pf_valid_q
		&& !mem_req_q && !pwu_req_q && fb_busy == '0 && swp_ready)
		else $error("outputs not idle after reset");
	a_l1_aligned:
	assert property (l1_pf_valid_q |-> l1_pf_addr_q[5:0] == 6'h00)
		else $error("l1 prefetch not line aligned");
	a_l2_aligned:
	assert property (l2_pf_valid_q |-> l2_pf_addr_q[5:0] == 6'h00)
		else $error("l2 prefetch not line aligned");
	a_mem_follows_l2:
	assert property (mem_req_q |-> l2_pf_valid_q && mem_addr_q == l2_pf_addr_q)
		else $error("memory request without matching l2 prefetch");
	a_walk_starts:
	assert property (sw_take && !swp_tlb_hit |=> pwu_req_q
		&& pwu_addr_q == $past(swp_addr))
		else $error("tlb miss did not start a walk");
	a_walk_blocks:
	assert property (sw_take && !swp_tlb_hit |=> !swp_ready)
		else $error("hint accepted during walk");
	a_sw_l1_line:
	assert property (sw_take && swp_tlb_hit && !prefetch_to_l2_hint
		|-> ##2 !l1_pf_valid_q || l1_pf_addr_q == $past(sw_line, 2))
		else $error("l1 software prefetch wrong line");
	a_l2_no_fb:
	assert property (sw_take && swp_tlb_hit && prefetch_to_l2_hint
		|-> ##2 !(l1_pf_valid_q && l1_pf_addr_q == $past(sw_line, 2))
		&& $countones(fb_busy) <= $countones($past(fb_busy)))
		else $error("l2 software prefetch took a fill buffer");
	a_sw_l2_line:
	assert property (sw_take && swp_tlb_hit && prefetch_to_l2_hint
		|-> ##2 !l2_pf_valid_q || l2_pf_addr_q == $past(sw_line, 2))
		else $error("l2 software prefetch wrong line");
endmodule

bind thpf_top thpf_assertions #(.AW(AW), .FBN(FBN)) i_thpf_assertions (
	.mclk(mclk), .sys_rst(sys_rst), .swp_valid(swp_valid),
	.swp_ready(swp_ready), .swp_addr(swp_addr),
	.prefetch_to_l2_hint(prefetch_to_l2_hint), .swp_tlb_hit(swp_tlb_hit),
	.pwu_req_q(pwu_req_q), .pwu_addr_q(pwu_addr_q),
	.l1_pf_valid_q(l1_pf_valid_q), .l1_pf_addr_q(l1_pf_addr_q),
	.fb_busy(fb_busy), .l2_pf_valid_q(l2_pf_valid_q),
	.l2_pf_addr_q(l2_pf_addr_q), .mem_req_q(mem_req_q),
	.mem_addr_q(mem_addr_q)
);

/* verification/thpf_cache_model.sv */
// behavioural far side: l1, l2 and the page walker
// assumes registered request pulses from the prefetch unit
`timescale 1ns/1ps
module thpf_cache_model (
	// clock and reset
	input  wire        mclk,
	input  wire        sys_rst,
	// bench controls
	input  wire        slow,
	input  wire        l1_hit,
	input  wire        l2_hit,
	// walker and caches
	input  wire        pwu_req_q,
	output reg         pwu_done,
	input  wire        l1_pf_valid_q,
	input  wire [39:0] l1_pf_addr_q,
	output wire        l1_pf_ready,
	output wire        l1_present,
	output reg         l1_fill_done,
	output reg  [39:0] l1_fill_addr,
	output wire        l2_pf_ready,
	output wire        l2_present
);
	logic [39:0] fq[$];
	int          walk_n;
	int          fill_n;

	// presence is forced by the bench, no tag store kept
	assign l1_pf_ready = 1'b1;
	assign l2_pf_ready = 1'b1;
	assign l1_present  = l1_hit;
	assign l2_present  = l2_hit;

	// fills complete in order; stale fill address keeps toggling
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pwu_done     <= 1'b0;
			l1_fill_done <= 1'b0;
			l1_fill_addr <= 40'h0;
			walk_n       <= 0;
			fill_n       <= 0;
			fq.delete();
		end else begin
			pwu_done     <= (walk_n == 1);
			l1_fill_done <= 1'b0;
			l1_fill_addr <= ~l1_fill_addr;
			if (pwu_req_q)
				walk_n <= slow ? 9 : 3;
			else if (walk_n != 0)
				walk_n <= walk_n - 1;
			if (l1_pf_valid_q)
				fq.push_back(l1_pf_addr_q);
			if (fq.size() != 0 && fill_n >= (slow ? 12 : 4)) begin
				l1_fill_done <= 1'b1;
				l1_fill_addr <= fq.pop_front();
				fill_n       <= 0;
			end else if (fq.size() != 0)
				fill_n <= fill_n + 1;
		end
	end
endmodule

/* verification/thpf_tb.sv */
// self-checking bench for the tile prefetch unit
// assumes the cache model answers walks and fills
`timescale 1ns/1ps
module tb;
	logic        mclk, sys_rst, acc_valid, acc_lp, acc_cacheable;
	logic [39:0] acc_addr, acc_pc, swp_addr;
	logic        swp_valid, prefetch_to_l2_hint, swp_tlb_hit;
	logic        slow, l1_hit, l2_hit;
	wire         swp_ready, pwu_req_q, pwu_done, l1_pf_valid_q, l1_pf_ready;
	wire         l1_present, l1_fill_done, l2_pf_valid_q, l2_pf_ready;
	wire         l2_present, mem_req_q;
	wire  [39:0] pwu_addr_q, l1_pf_addr_q, l1_fill_addr, l2_pf_addr_q;
	wire  [39:0] mem_addr_q;
	wire  [7:0]  fb_busy;
	int          fails, n_compared;

	thpf_top i_thpf_top (.mclk(mclk), .sys_rst(sys_rst),
		.acc_valid(acc_valid), .acc_addr(acc_addr), .acc_pc(acc_pc),
		.acc_lp(acc_lp), .acc_cacheable(acc_cacheable),
		.swp_valid(swp_valid), .swp_ready(swp_ready), .swp_addr(swp_addr),
		.prefetch_to_l2_hint(prefetch_to_l2_hint), .swp_tlb_hit(swp_tlb_hit),
		.pwu_req_q(pwu_req_q), .pwu_addr_q(pwu_addr_q), .pwu_done(pwu_done),
		.l1_pf_valid_q(l1_pf_valid_q), .l1_pf_addr_q(l1_pf_addr_q),
		.l1_pf_ready(l1_pf_ready), .l1_present(l1_present),
		.l1_fill_done(l1_fill_done), .l1_fill_addr(l1_fill_addr),
		.fb_busy(fb_busy), .l2_pf_valid_q(l2_pf_valid_q),
		.l2_pf_addr_q(l2_pf_addr_q), .l2_pf_ready(l2_pf_ready),
		.l2_present(l2_present), .mem_req_q(mem_req_q),
		.mem_addr_q(mem_addr_q));
	thpf_cache_model i_thpf_cache_model (.mclk(mclk), .sys_rst(sys_rst),
		.slow(slow), .l1_hit(l1_hit), .l2_hit(l2_hit),
		.pwu_req_q(pwu_req_q), .pwu_done(pwu_done),
		.l1_pf_valid_q(l1_pf_valid_q), .l1_pf_addr_q(l1_pf_addr_q),
		.l1_pf_ready(l1_pf_ready), .l1_present(l1_present),
		.l1_fill_done(l1_fill_done), .l1_fill_addr(l1_fill_addr),
		.l2_pf_ready(l2_pf_ready), .l2_present(l2_present));

	// 40 MHz clock
	always #12.5 mclk = ~mclk;

	task automatic chk(input logic [63:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic acc(input logic [39:0] a, pc, input logic lp, c);
		@(posedge mclk);
		acc_valid     <= 1'b1;
		acc_addr      <= a;
		acc_pc        <= pc;
		acc_lp        <= lp;
		acc_cacheable <= c;
	endtask
	task automatic idle;
		@(posedge mclk);
		acc_valid <= 1'b0;
	endtask
	// three accesses two lines apart from one pc
	task automatic t_stride(input logic [39:0] b, pc, input logic lp3, c, e);
		logic        seen;
		logic [39:0] got;
		seen = 1'b0;
		got  = '0;
		acc(b, pc, 1'b0, c);
		acc(b + 40'h80, pc, 1'b0, c);
		acc(b + 40'h100, pc, lp3, c);
		idle;
		repeat (8) begin
			@(negedge mclk);
			if (l1_pf_valid_q === 1'b1 && !seen) begin
				seen = 1'b1;
				got  = l1_pf_addr_q;
			end
		end
		chk(seen, e);
		if (e)
			chk(got, b + 40'h180);
	endtask
	// two neighbouring lines from different processors, then watch l2
	task automatic t_stream(input logic [39:0] a, input logic dn, int n_exp);
		int          n;
		logic [39:0] nx;
		n  = 0;
		nx = dn ? a - 40'h40 : a + 40'h40;
		acc(a, 40'h100, 1'b0, 1'b1);
		acc(nx, 40'h200, 1'b1, 1'b1);
		idle;
		nx = dn ? nx - 40'h40 : nx + 40'h40;
		// dropped lines still walk the stream, so wait out a whole page
		repeat (64) begin
			@(negedge mclk);
			if (l2_pf_valid_q === 1'b1) begin
				chk(l2_pf_addr_q, nx);
				chk({mem_req_q, mem_addr_q}, {1'b1, nx});
				nx = dn ? nx - 40'h40 : nx + 40'h40;
				n++;
			end
		end
		chk(n, n_exp);
	endtask
	// one software hint, then its issue and fill buffer use
	task automatic t_sw(input logic [39:0] a, input logic l2h, hit);
		int   w;
		logic walked;
		w      = 0;
		walked = 1'b0;
		@(posedge mclk);
		swp_valid           <= 1'b1;
		swp_addr            <= a;
		prefetch_to_l2_hint <= l2h;
		swp_tlb_hit         <= hit;
		do begin
			@(negedge mclk);
			w++;
		end while (swp_ready !== 1'b1 && w < 40);
		@(posedge mclk);
		swp_valid <= 1'b0;
		do begin
			@(negedge mclk);
			w++;
			walked = walked | (pwu_req_q === 1'b1);
		end while ((l2h ? l2_pf_valid_q : l1_pf_valid_q) !== 1'b1 && w < 80);
		if (w >= 80) begin
			chk(w, 0);
			stop_test;
		end
		chk(walked, !hit);
		chk(l2h ? l2_pf_addr_q : l1_pf_addr_q, {a[39:6], 6'h00});
		chk(|fb_busy, !l2h);
		if (l2h)
			chk(mem_req_q, 1'b1);
		else begin
			w = 0;
			while (l1_fill_done !== 1'b1 && w < 40) begin
				@(negedge mclk);
				w++;
			end
			if (w >= 40) begin
				chk(w, 0);
				stop_test;
			end
			@(negedge mclk);
			chk(fb_busy, 8'h00);
		end
	endtask

	initial begin
		mclk = 1'b0;
		sys_rst = 1'b1;
		{acc_valid, acc_lp, acc_cacheable, acc_addr, acc_pc} = '0;
		{swp_valid, swp_addr, prefetch_to_l2_hint, swp_tlb_hit} = '0;
		{slow, l1_hit, l2_hit} = '0;
		fails = 0;
		n_compared = 0;
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		t_stride(40'h1000, 40'h400, 1'b0, 1'b1, 1'b1);
		t_stride(40'h2040, 40'h480, 1'b1, 1'b1, 1'b0);
		t_stride(40'h2e80, 40'h500, 1'b0, 1'b1, 1'b0);
		t_stride(40'h3000, 40'h540, 1'b0, 1'b0, 1'b0);
		l1_hit <= 1'b1;
		t_stride(40'h4000, 40'h580, 1'b0, 1'b1, 1'b0);
		l1_hit <= 1'b0;
		t_stream(40'h10f00, 1'b0, 2);
		t_stream(40'h11080, 1'b1, 1);
		l2_hit <= 1'b1;
		t_stream(40'h12400, 1'b0, 0);
		l2_hit <= 1'b0;
		t_sw(40'h5123, 1'b0, 1'b1);
		t_sw(40'h6a47, 1'b1, 1'b1);
		slow <= 1'b1;
		t_sw(40'h7fc9, 1'b0, 1'b0);
		t_sw(40'h8001, 1'b1, 1'b0);
		stop_test;
	end
endmodule
